// File: rtl/fsp_top.sv
// Purpose: Turn-off style control, protection status register, fault line propagation
// Assumes: Protection detectors give synchronous levels; fault line is wired-AND open drain
// Notes: Flags are active low; a peer collision on the line decodes as the wider code
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
//
// Behaviour
// [RQ1] Sequenced style ramps output down at programmed ramp-down rate.
// [RQ2] Critical style turns both power switches off at once.
// [RQ3] Emergency style turns upper switch off and lower switch on together.
// [RQ4] Overtemp, undervoltage and overvoltage each have their own selectable style.
// [RQ5] Eight-bit status register lives at address 0x16.
// [RQ6] Bit 7 temperature warning, bit 6 power-good warning; read-only, reset 1 and 0.
// [RQ7] Bits 5..2 tracking, overtemp, overcurrent, undervoltage faults; writable, reset 1.
// [RQ8] Bit 1 overvoltage error, writable, reset 1; bit 0 reserved.
// [RQ9] Manager reads each status register and shows it for monitoring.
// [RQ10] Propagating fault pulls the shared fault line low.
// [RQ11] Line pulled low by another device starts own shutdown in same style.
// [RQ12] Style is coded as the low-pulse width from the falling edge of the line; the receiver decodes it from that width when the line rises.
// [RQ13] Manager groups regulators sharing one fault input, up to 32.
// [RQ14] Only fault types with propagation enabled drive the line.
// [RQ15] Protection event shuts down and clears its status bit to 0.
// [RQ16] Non-latching retries every 130 ms; latching stays off until cleared.
// [RQ17] Writing 1 to a fault bit clears it back to 1.
// [RQ18] Line style coding is shared identically by all drivers and receivers.
module fsp_top #(
  parameter int RETRY_CYCLES = `FSP_RETRY_CYCLES,
  parameter int SLOT_CYCLES = `FSP_SLOT_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Protection inputs and configuration
  input wire fsp_pkg::fsp_event_t ev,
  input wire logic temp_warn,
  input wire logic pg_warn,
  input wire fsp_pkg::fsp_cfg_t cfg,
  // Output stage control
  output fsp_pkg::fsp_stage_t stage,
  // Shared fault line
  input wire logic ok_in,
  output logic ok_out,
  output logic ok_oe
);
  import fsp_pkg::*;
  typedef enum logic [1:0] {S_RUN = 2'h1, S_OFF = 2'h2} fsp_sd_t;
  typedef enum logic [3:0] {T_IDLE = 4'h1, T_MARK = 4'h2, T_GAP = 4'h4, T_HOLD = 4'h8} fsp_tx_t;
  typedef enum logic [2:0] {R_IDLE = 3'h1, R_MEAS = 3'h2, R_WAIT = 3'h4} fsp_rx_t;
  localparam int MAXC = 4 * SLOT_CYCLES;

  function automatic fsp_style_t cfg_style(input logic [1:0] c);
    if (c == `FSP_STYLE_CFG_SEQ) begin
      return FSP_SEQ;
    end else if (c == `FSP_STYLE_CFG_CRIT) begin
      return FSP_CRIT;
    end
    return FSP_EMER;
  endfunction : cfg_style

  // Severity order decides the style when several trip together
  function automatic fsp_style_t pick(input logic [4:0] v, input fsp_cfg_t c);
    if (v[0]) begin
      return cfg_style(c.ov_style); // RQ4
    end else if (v[4] || v[2]) begin
      return FSP_CRIT;
    end else if (v[3]) begin
      return cfg_style(c.ot_style); // RQ4
    end
    return cfg_style(c.uv_style); // RQ4
  endfunction : pick

  function automatic logic [5:0] code_len(input fsp_style_t s);
    if (s == FSP_SEQ) begin
      return 6'(SLOT_CYCLES);
    end else if (s == FSP_CRIT) begin
      return 6'(2 * SLOT_CYCLES);
    end
    return 6'(3 * SLOT_CYCLES);
  endfunction : code_len

  logic [4:0] evv;
  logic [4:0] flt_n, next_flt_n;
  logic tw, next_tw, pg, next_pg;
  fsp_sd_t sd, next_sd;
  fsp_style_t style, next_style;
  fsp_stage_t next_stage;
  logic [7:0] next_rdata;
  logic retry_done, wr_hit, prop_req, rx_start;
  fsp_style_t rx_style;
  assign evv = ev;
  assign wr_hit = reg_wr && (reg_addr == `FSP_ADDR_STATUS);
  assign prop_req = |(~flt_n & cfg.prop);

  fsp_retry_timer #(.CYCLES(RETRY_CYCLES)) u_retry (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(sd == S_OFF),
    .done(retry_done)
  );

  // Status flags and shutdown control
  always_comb begin
    next_tw = ~temp_warn; // RQ6
    next_pg = ~pg_warn; // RQ6
    next_flt_n = flt_n;
    for (int i = 0; i < 5; i++) begin
      if (evv[i]) begin
        next_flt_n[i] = 1'b0; // RQ15
      end else if (wr_hit && reg_wdata[i + `FSP_BIT_FLT_LO]) begin
        next_flt_n[i] = 1'b1; // RQ17
      end else if (retry_done && !cfg.latch[i]) begin
        next_flt_n[i] = 1'b1; // RQ16
      end
    end
    next_sd = sd;
    next_style = style;
    case (sd)
      S_RUN: begin
        if (|(evv & flt_n)) begin
          next_sd = S_OFF; // RQ15
          next_style = pick(evv & flt_n, cfg); // RQ4
        end else if (rx_start) begin
          next_sd = S_OFF; // RQ11
          next_style = rx_style; // RQ11
        end
      end
      S_OFF: begin
        // Restart only on a retry tick; our own hold on the line must not cost an interval
        if (retry_done && (&next_flt_n) && (ok_in || ok_oe)) begin
          next_sd = S_RUN; // RQ16
        end
      end
      default: begin
        next_sd = S_OFF;
      end
    endcase
    next_stage.run = (next_sd == S_RUN);
    next_stage.ramp_down = (next_sd == S_OFF) && (next_style == FSP_SEQ); // RQ1
    next_stage.hs_force_off = (next_sd == S_OFF) && (next_style != FSP_SEQ); // RQ2
    next_stage.ls_force_on = (next_sd == S_OFF) && (next_style == FSP_EMER); // RQ3
    next_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == `FSP_ADDR_STATUS) begin
        next_rdata = {tw, pg, flt_n, 1'b1}; // RQ5
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tw <= 1'(`FSP_STATUS_RESET >> `FSP_BIT_TEMP_WARN); // RQ6
      pg <= 1'b0;
      flt_n <= 5'(`FSP_STATUS_RESET >> `FSP_BIT_FLT_LO); // RQ7 RQ8
      sd <= S_OFF;
      style <= FSP_SEQ;
      stage <= 4'h4;
      reg_rdata <= 8'h00;
    end else begin
      tw <= next_tw;
      pg <= next_pg;
      flt_n <= next_flt_n;
      sd <= next_sd;
      style <= next_style;
      stage <= next_stage;
      reg_rdata <= next_rdata;
    end
  end

  // Transmitter: low for one to three slots, one released slot, then held low
  fsp_tx_t tx, next_tx;
  logic [5:0] tcnt, next_tcnt;
  logic next_oe;
  always_comb begin
    next_tx = tx;
    next_tcnt = tcnt + 6'h1;
    case (tx)
      T_IDLE: begin
        next_tcnt = 6'h0;
        if (prop_req) begin
          next_tx = ok_in ? T_MARK : T_HOLD; // RQ10
        end
      end
      T_MARK: begin
        if (tcnt + 6'h1 >= code_len(pick(~flt_n & cfg.prop, cfg))) begin
          next_tx = T_GAP; // RQ12
          next_tcnt = 6'h0;
        end
      end
      T_GAP: begin
        if (tcnt + 6'h1 >= 6'(SLOT_CYCLES)) begin
          next_tx = T_HOLD; // RQ18
        end
      end
      T_HOLD: begin
        if (!prop_req) begin
          next_tx = T_IDLE; // RQ14
        end
      end
      default: begin
        next_tx = T_IDLE;
      end
    endcase
    next_oe = (next_tx == T_MARK) || (next_tx == T_HOLD); // RQ14
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx <= T_IDLE;
      tcnt <= 6'h0;
      ok_oe <= 1'b0;
      ok_out <= 1'b0;
    end else begin
      tx <= next_tx;
      tcnt <= next_tcnt;
      ok_oe <= next_oe;
      ok_out <= 1'b0;
    end
  end

  // Receiver: measures the first low pulse; a line stuck low decodes as critical
  fsp_rx_t rx, next_rx;
  logic [5:0] rcnt, next_rcnt;
  logic ok_q;
  always_comb begin
    next_rx = rx;
    next_rcnt = rcnt + 6'h1;
    rx_start = 1'b0;
    rx_style = FSP_CRIT;
    if (rcnt < 6'(SLOT_CYCLES + SLOT_CYCLES / 2)) begin
      rx_style = FSP_SEQ; // RQ12
    end else if (rcnt >= 6'(2 * SLOT_CYCLES + SLOT_CYCLES / 2)) begin
      rx_style = FSP_EMER; // RQ12
    end
    case (rx)
      R_IDLE: begin
        next_rcnt = 6'h0;
        if (ok_q && !ok_in && (tx == T_IDLE) && !ok_oe) begin
          next_rx = R_MEAS;
        end
      end
      R_MEAS: begin
        if (ok_in || (rcnt + 6'h1 >= 6'(MAXC))) begin
          rx_start = 1'b1; // RQ11
          if (!ok_in) begin
            rx_style = FSP_CRIT;
          end
          next_rx = R_WAIT;
          next_rcnt = 6'h0;
        end
      end
      R_WAIT: begin
        if (!ok_in) begin
          next_rcnt = 6'h0;
        end else if (rcnt + 6'h1 >= 6'(2 * SLOT_CYCLES)) begin
          next_rx = R_IDLE;
        end
      end
      default: begin
        next_rx = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx <= R_IDLE;
      rcnt <= 6'h0;
      ok_q <= 1'b1;
    end else begin
      rx <= next_rx;
      rcnt <= next_rcnt;
      ok_q <= ok_in;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_OV_CLEARS: assert property (ev.overvoltage |=> !flt_n[0]) // RQ15
    else $error("overvoltage flag not cleared");
  AST_EMER_PAIR: assert property (stage.ls_force_on |-> stage.hs_force_off && !stage.run) // RQ3
    else $error("lower switch on without upper off");
  AST_CRIT_NORAMP: assert property (stage.hs_force_off |-> !stage.ramp_down) // RQ2
    else $error("critical shutdown ramps");
  AST_SEQ_RAMP: assert property (sd == S_OFF && style == FSP_SEQ |=> $past(stage.ramp_down) == 1'b0 || stage.ramp_down || stage.run) // RQ1
    else $error("sequenced shutdown without ramp");
  AST_STATUS_READ: assert property (reg_rd && reg_addr == 8'h16 |=> reg_rdata[5:0] == {$past(flt_n), 1'b1}) // RQ5
    else $error("status read mismatch");
  AST_W1C: assert property (wr_hit && reg_wdata[1] && !ev.overvoltage |=> flt_n[0]) // RQ17
    else $error("write one did not clear flag");
  AST_NO_PROP: assert property (!prop_req && tx == T_IDLE |=> !ok_oe) // RQ14
    else $error("line driven without propagation");
  AST_PROP_DRIVE: assert property (prop_req && tx == T_IDLE |=> ok_oe) // RQ10
    else $error("propagating fault not driven");
  AST_RX_SHUT: assert property (rx_start && sd == S_RUN && !(|(evv & flt_n)) |=> !stage.run && style == $past(rx_style)) // RQ11
    else $error("remote fault did not shut down");
  AST_OT_STYLE: assert property (sd == S_RUN && (evv & flt_n) == 5'h08 |=> style == cfg_style($past(cfg.ot_style))) // RQ4
    else $error("overtemp style wrong");
  AST_RO_BITS: assert property (reg_rd && reg_addr == 8'h16 |=> reg_rdata[7] == !$past(temp_warn, 2) || $past(sys_rst, 2)) // RQ6
    else $error("temperature warning bit wrong");
  COV_EMER: cover property (sd == S_RUN ##1 stage.ls_force_on);
  COV_TX_CODE: cover property (tx == T_MARK ##1 tx == T_GAP ##1 tx == T_GAP);
  COV_RX: cover property (rx_start && rx_style == FSP_EMER);
  COV_RETRY: cover property (sd == S_OFF ##1 sd == S_RUN);
endmodule : fsp_top
`default_nettype wire

// File: include/fsp_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 10 MHz core clock
// Notes: Definitions only
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH
`define FSP_ADDR_STATUS 8'h16
`define FSP_BIT_TEMP_WARN 7
`define FSP_BIT_PG_WARN 6
`define FSP_BIT_FLT_HI 5
`define FSP_BIT_FLT_LO 1
`define FSP_BIT_RESERVED 0
`define FSP_STATUS_RESET 8'hBF
`define FSP_CLK_KHZ 10000
`define FSP_RETRY_MS 130
`define FSP_RETRY_CYCLES (`FSP_RETRY_MS * `FSP_CLK_KHZ)
`define FSP_SLOT_CYCLES 4
`define FSP_STYLE_CFG_SEQ 2'h0
`define FSP_STYLE_CFG_CRIT 2'h1
`endif

// File: include/fsp_pkg.sv
// Purpose: Types shared by the fault status and propagation block
// Assumes: Constants come from fsp_regs.svh
// Notes: Fault vector order is tracking, overtemp, overcurrent, undervoltage, overvoltage
`default_nettype none
package fsp_pkg;
  typedef enum logic [2:0] {
    FSP_SEQ = 3'h1,
    FSP_CRIT = 3'h2,
    FSP_EMER = 3'h4
  } fsp_style_t;
  typedef struct packed {
    logic tracking;
    logic overtemp;
    logic overcurrent;
    logic undervoltage;
    logic overvoltage;
  } fsp_event_t;
  typedef struct packed {
    logic [4:0] latch;
    logic [4:0] prop;
    logic [1:0] ot_style;
    logic [1:0] uv_style;
    logic [1:0] ov_style;
  } fsp_cfg_t;
  typedef struct packed {
    logic run;
    logic ramp_down;
    logic hs_force_off;
    logic ls_force_on;
  } fsp_stage_t;
endpackage : fsp_pkg
`default_nettype wire

// File: rtl/fsp_retry_timer.sv
// Purpose: Free retry interval timer, one done pulse per interval while running
// Assumes: Synchronous run level
// Notes: Restarts from zero whenever run drops
`timescale 1ns/1ps
`default_nettype none
module fsp_retry_timer #(
  parameter int CYCLES = 1300000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic run,
  output logic done
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic next_done;
  always_comb begin
    next_cnt = 32'h0;
    next_done = 1'b0;
    if (run) begin
      if (cnt >= 32'(CYCLES - 1)) begin
        next_done = 1'b1;
      end else begin
        next_cnt = cnt + 32'h1;
      end
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 32'h0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule : fsp_retry_timer
`default_nettype wire

// File: tb/fsp_peer.sv
// Purpose: Peer regulator and manager seen on the shared fault line
// Assumes: Line has a pull-up
// Notes: Peer marks its style as a low time of n slots
`timescale 1ns/1ps
`default_nettype none
module fsp_peer #(
  parameter int SLOT = 4
) (
  // Clock
  input wire logic mclk,
  // Line
  input wire logic dev_pull,
  output logic ok_line
);
  logic peer_pull = 1'b0;
  // Released line goes to the pull-up level, never holds a stale value
  assign ok_line = ~(dev_pull | peer_pull);
  task automatic send(input int n);
    @(posedge mclk) peer_pull <= 1'b1;
    repeat (n * SLOT) @(posedge mclk);
    peer_pull <= 1'b0;
  endtask : send
endmodule : fsp_peer
`default_nettype wire

// File: tb/test_fsp_top.sv
// Purpose: Self-checking bench for the fault status block
// Assumes: Short retry interval, four-cycle slot
// Notes: Expected values come from a small flag model
`timescale 1ns/1ps
`default_nettype none
`include "fsp_regs.svh"
module test_fsp_top;
  import fsp_pkg::*;
  localparam int RETRY = 200;
  localparam int SLOT = 4;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  fsp_event_t ev = 5'h00;
  logic temp_warn = 1'b0;
  logic pg_warn = 1'b1;
  fsp_cfg_t cfg = 16'h0000;
  fsp_stage_t stage;
  logic ok_in;
  logic ok_out;
  logic ok_oe;
  logic [7:0] d;
  logic [4:0] m_flags = 5'h1F;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  fsp_top #(.RETRY_CYCLES(RETRY), .SLOT_CYCLES(SLOT)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ev(ev),
    .temp_warn(temp_warn), .pg_warn(pg_warn), .cfg(cfg), .stage(stage),
    .ok_in(ok_in), .ok_out(ok_out), .ok_oe(ok_oe));
  fsp_peer #(.SLOT(SLOT)) peer (.mclk(mclk), .dev_pull(ok_oe & ~ok_out), .ok_line(ok_in));
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  task automatic bad(input string msg);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : bad
  task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) bad($sformatf("reg %h want %h", got, exp));
  endtask : chk_reg
  task automatic chk_stage(input int code, input fsp_stage_t got);
    fsp_stage_t exp;
    exp = (code == 0) ? 4'h4 : (code == 1) ? 4'h2 : 4'h3;
    total_checks++;
    if (got !== exp) bad($sformatf("stage %h want %h", got, exp));
  endtask : chk_stage
  task automatic chk_cnt(input int exp, input int got);
    total_checks++;
    if (got != exp) bad($sformatf("count %0d want %0d", got, exp));
  endtask : chk_cnt
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic chk_st();
    logic [7:0] q;
    rd(8'h16, q);
    chk_reg({~temp_warn, ~pg_warn, m_flags, 1'b1}, q);
  endtask : chk_st
  task automatic wait_run(input int lim);
    int n;
    n = 0;
    while (stage.run !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    if (stage.run !== 1'b1) bad("no restart");
  endtask : wait_run
  // Bounded so a stuck line cannot hang the run
  task automatic cnt_while(input logic lvl, output int n);
    n = 0;
    while (ok_oe === lvl && n < 40) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask : cnt_while
  task automatic fault_case(input int idx, input int sty, input bit lat, input bit prp);
    logic [5:0] s;
    int code;
    int n;
    int t0;
    wait_run(2 * RETRY + 20);
    s = 6'($urandom);
    if (idx == 0) s[1:0] = 2'(sty);
    if (idx == 1) s[3:2] = 2'(sty);
    if (idx == 3) s[5:4] = 2'(sty);
    code = (idx == 2 || idx == 4) ? 1 : (idx == 0) ? s[1:0] : (idx == 1) ? s[3:2] : s[5:4];
    @(posedge mclk);
    cfg <= {lat ? 5'(1 << idx) : 5'h00, prp ? 5'(1 << idx) : 5'h00, s};
    temp_warn <= 1'($urandom);
    @(posedge mclk);
    ev <= 5'(1 << idx);
    @(posedge mclk);
    ev <= 5'h00;
    #1 chk_stage(code, stage);
    t0 = cyc;
    m_flags[idx] = 1'b0;
    cnt_while(1'b0, n);
    if (prp) begin
      cnt_while(1'b1, n);
      chk_cnt((code > 1 ? 3 : code + 1) * SLOT, n);
      cnt_while(1'b0, n);
      chk_cnt(SLOT, n);
      chk_cnt(1, int'(ok_oe === 1'b1));
      chk_cnt(0, int'(ok_out !== 1'b0));
    end else begin
      chk_cnt(40, n);
    end
    chk_st();
    if (lat) begin
      wr(8'h16, 8'(1 << (idx + 1)));
      m_flags[idx] = 1'b1;
      chk_st();
    end
    wait_run(2 * RETRY + 20);
    chk_cnt(RETRY + 1, cyc - t0);
    m_flags[idx] = 1'b1;
    chk_st();
    $display("fault case %0d style %0d done", idx, code);
  endtask : fault_case
  task automatic peer_case(input int code);
    int n;
    wait_run(2 * RETRY + 20);
    peer.send(code > 1 ? 3 : code + 1);
    n = 0;
    while (stage.run === 1'b1 && n < 6) begin
      @(posedge mclk);
      #1 n++;
    end
    chk_stage(code, stage);
    $display("peer case %0d done", code);
  endtask : peer_case
  initial begin
    void'($urandom(32'h3b60));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'h16, d);
    chk_reg(`FSP_STATUS_RESET, d);
    rd(8'h17, d);
    chk_reg(8'h00, d);
    @(posedge mclk);
    pg_warn <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      fault_case(i % 5, i % 4, 1'b1, 1'b1);
    end
    fault_case(3, 2, 1'b0, 1'b1);
    fault_case(1, 1, 1'b1, 1'b0);
    for (int c = 0; c < 3; c++) begin
      peer_case(c);
    end
    close_out();
  end
endmodule : test_fsp_top
`default_nettype wire
